// ==== rtl/ccs_pkg.sv ====
// Constants, states and carrier types of the clock synthesizer register bank.
// Assumes a single 10 MHz system clock domain.
package ccs_pkg;
  // ----------------------------------------------------------------
  // Byte offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] CCS_OFF_IDENT = 7'h00;
  localparam logic [6:0] CCS_OFF_CTRL = 7'h01;
  localparam logic [6:0] CCS_OFF_OUTSEL = 7'h02;
  localparam logic [6:0] CCS_OFF_PLLA = 7'h10;
  localparam logic [6:0] CCS_OFF_PLLB = 7'h20;
  localparam logic [6:0] CCS_OFF_A_FREQ = 7'h13;
  localparam logic [6:0] CCS_OFF_A_STATE = 7'h15;
  localparam logic [6:0] CCS_OFF_B_FREQ = 7'h23;
  localparam logic [6:0] CCS_OFF_B_STATE = 7'h25;
  // ----------------------------------------------------------------
  // Field positions and write masks
  // ----------------------------------------------------------------
  localparam int CCS_BIT_NVM_BUSY = 6;
  localparam int CCS_BIT_LOCK = 5;
  localparam int CCS_BIT_PDN = 4;
  localparam int CCS_BIT_OUTSRC = 7;
  localparam int CCS_BIT_PINROLE = 6;
  localparam int CCS_BIT_SINGLE = 7;
  localparam logic [7:0] CCS_WMASK_CTRL = 8'h3f;
  localparam logic [7:0] CCS_WMASK_OUTSEL = 8'hc0;
  // ----------------------------------------------------------------
  // Reset values and identity
  // ----------------------------------------------------------------
  localparam logic [7:0] CCS_RST_CTRL = 8'h00;
  localparam logic [7:0] CCS_RST_OUTSEL = 8'h00;
  localparam logic [7:0] CCS_RST_TABLE = 8'h00;
  localparam logic [2:0] CCS_RST_PINS = 3'h3;
  // Identity values are arbitrary
  localparam logic CCS_IDENT_FLAG = 1'h1;
  localparam logic [2:0] CCS_REVISION = 3'h2;
  localparam logic [3:0] CCS_VENDOR = 4'h5;
  localparam logic [4:0] CCS_ADDR_BASE = 5'h19;
  localparam logic [3:0] CCS_BYTE_BITS = 4'h8;
  localparam logic [2:0] CCS_B_RSVD_LO = 3'h3;
  localparam logic [2:0] CCS_B_RSVD_HI = 3'h4;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {CCS_IDLE, CCS_RECV, CCS_ACK, CCS_SEND, CCS_RACK} ccs_state_t;
  typedef enum logic [1:0] {CCS_K_ADDR, CCS_K_CMD, CCS_K_DATA} ccs_kind_t;
  typedef struct packed {
    logic a_freq;
    logic a_state;
    logic b_freq;
    logic b_state;
  } ccs_pll_sel_t;
endpackage

// ==== rtl/ccs_regs.sv ====
// Configuration register bank with its 2-wire serial slave port.
// Assumes the NVM controller drives its busy and stored pin-role levels on clk_in.
//
// What this block does
// (RQ1) Master leaves identification byte zero untouched during block writes.
// (RQ2) Accept serial writes to generic 00h, PLL A 10h, PLL B 20h regions.
// (RQ3) Pick one of eight settings from three control pins, pin two most significant.
// (RQ4) PLL A bits from 13h/15h, PLL B from 23h/25h; B indices 3,4 reserved.
// (RQ5) Byte 00h read-only: ident flag bit 7, revision 6:4, vendor 3:0.
// (RQ6) Byte 01h bit 6 reads one while NVM programming runs.
// (RQ7) Byte 01h bit 5 holds the permanent NVM lock selection.
// (RQ8) Power-down overrides pin selection and leaves configuration intact.
// (RQ9) Power-down stops all PLLs and floats outputs; clear enables everything.
// (RQ10) Power-down bit is never stored as one in NVM.
// (RQ11) Byte 01h bits 3:2 choose crystal, VCXO, logic clock, or reserved.
// (RQ12) Byte 01h bits 1:0 give the two low slave address bits.
// (RQ13) Master always writes zero to reserved bit 7 of byte 01h.
// (RQ14) Byte 02h bit 7 routes input clock or PLL A clock onward.
// (RQ15) Byte 02h bit 6 makes dual pins serial lines or control pins.
// (RQ16) Command bit 7 zero means block, one means single byte; 6:0 offset.
// (RQ17) Every accepted data byte is stored and takes effect at once; bytes to 00h or unmapped offsets are acknowledged but dropped.
// (RQ18) During NVM write cycle incoming write data is refused; reads still served.
// (RQ19) Pin role changes only once the bit is held in NVM.
// (RQ20) Writes to read-only bits leave them and their neighbours intact.
`timescale 1ns/1ps
module ccs_regs (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ctrl_pin_zero_in,
  input wire logic nvm_programming_active_in,
  input wire logic nvm_pin_role_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output ccs_pkg::ccs_pll_sel_t pll_settings_out,
  output logic pll_power_down_out,
  output logic outputs_hiz_out,
  output logic [1:0] input_clock_source_out,
  output logic output_source_select_out,
  output logic nvm_permanent_lock_out,
  output logic pin_role_active_out,
  output logic [7:0] nvm_ctrl_image_out
);
  import ccs_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers: bit 0 data line, bit 1 clock line, bit 2 pin zero
  // ----------------------------------------------------------------
  logic [2:0] sync_a, sync_b, sync_c, filt, prev;
  logic [2:0] next_sync_a, next_sync_b, next_sync_c, next_filt, next_prev;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_comb begin
    next_sync_a = {ctrl_pin_zero_in, scl_in, sda_in};
    next_sync_b = sync_a;
    next_sync_c = sync_b;
    next_prev = filt;
    // A level is taken only once the last two stages agree
    for (int i = 0; i < 3; i++) begin
      next_filt[i] = (sync_b[i] == sync_c[i]) ? sync_c[i] : filt[i];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_a <= CCS_RST_PINS;
      sync_b <= CCS_RST_PINS;
      sync_c <= CCS_RST_PINS;
      filt <= CCS_RST_PINS;
      prev <= CCS_RST_PINS;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_c <= next_sync_c;
      filt <= next_filt;
      prev <= next_prev;
    end
  end

  assign scl_rise = filt[1] & ~prev[1];
  assign scl_fall = ~filt[1] & prev[1];
  assign bus_start = filt[1] & prev[1] & prev[0] & ~filt[0];
  assign bus_stop = filt[1] & prev[1] & ~prev[0] & filt[0];

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] r01, r02, r13, r15, r23, r25;
  logic [7:0] next_r01, next_r02, next_r13, next_r15, next_r23, next_r25;
  logic wr_en;
  logic [6:0] wr_off, offset;
  logic [7:0] wr_data, rd_byte;

  function automatic logic [7:0] ccs_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] mask);
    ccs_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic [7:0] ccs_read(input logic [6:0] off);
    case (off)
      CCS_OFF_IDENT: ccs_read = {CCS_IDENT_FLAG, CCS_REVISION, CCS_VENDOR}; // RQ5
      CCS_OFF_CTRL: ccs_read = {r01[7], nvm_programming_active_in, r01[5:0]}; // RQ6
      CCS_OFF_OUTSEL: ccs_read = r02;
      CCS_OFF_A_FREQ: ccs_read = r13;
      CCS_OFF_A_STATE: ccs_read = r15;
      CCS_OFF_B_FREQ: ccs_read = r23;
      CCS_OFF_B_STATE: ccs_read = r25;
      default: ccs_read = 8'h00;
    endcase
  endfunction

  assign rd_byte = ccs_read(offset);

  always_comb begin
    next_r01 = r01;
    next_r02 = r02;
    next_r13 = r13;
    next_r15 = r15;
    next_r23 = r23;
    next_r25 = r25;
    // Masks keep busy flag and reserved bits out of reach; the identity byte has no write branch
    if (wr_en) begin // RQ17
      case (wr_off) // RQ2
        CCS_OFF_CTRL: next_r01 = ccs_merge(r01, wr_data, CCS_WMASK_CTRL); // RQ20
        CCS_OFF_OUTSEL: next_r02 = ccs_merge(r02, wr_data, CCS_WMASK_OUTSEL); // RQ20
        CCS_OFF_A_FREQ: next_r13 = wr_data;
        CCS_OFF_A_STATE: next_r15 = wr_data;
        CCS_OFF_B_FREQ: next_r23 = wr_data;
        CCS_OFF_B_STATE: next_r25 = wr_data;
        default: next_r13 = r13;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      r01 <= CCS_RST_CTRL;
      r02 <= CCS_RST_OUTSEL;
      r13 <= CCS_RST_TABLE;
      r15 <= CCS_RST_TABLE;
      r23 <= CCS_RST_TABLE;
      r25 <= CCS_RST_TABLE;
    end else begin
      r01 <= next_r01;
      r02 <= next_r02;
      r13 <= next_r13;
      r15 <= next_r15;
      r23 <= next_r23;
      r25 <= next_r25;
    end
  end

  // ----------------------------------------------------------------
  // Serial slave engine
  // ----------------------------------------------------------------
  // Data is driven about five cycles after the pin's falling edge, so the
  // line clock must stay low for at least six system clocks.
  ccs_state_t st, next_st;
  ccs_kind_t kind, next_kind;
  logic [3:0] bcnt, next_bcnt;
  logic [7:0] shreg, next_shreg;
  logic [6:0] next_offset;
  logic is_read, next_is_read, single, next_single, wrote, next_wrote;
  logic ack_ok, next_ack_ok, sda_low, next_sda_low;

  always_comb begin
    next_st = st;
    next_kind = kind;
    next_bcnt = bcnt;
    next_shreg = shreg;
    next_offset = offset;
    next_is_read = is_read;
    next_single = single;
    next_wrote = wrote;
    next_ack_ok = ack_ok;
    next_sda_low = sda_low;
    wr_en = 1'b0;
    wr_off = offset;
    wr_data = shreg;
    if (pin_role_active_out) begin // RQ15
      next_st = CCS_IDLE;
      next_sda_low = 1'b0;
    end else if (bus_start) begin
      next_st = CCS_RECV;
      next_kind = CCS_K_ADDR;
      next_bcnt = 4'h0;
      next_sda_low = 1'b0;
    end else if (bus_stop) begin
      next_st = CCS_IDLE;
      next_sda_low = 1'b0;
    end else begin
      case (st)
        CCS_RECV: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], filt[0]};
            next_bcnt = bcnt + 4'h1;
          end else if (scl_fall && bcnt == CCS_BYTE_BITS) begin
            next_bcnt = 4'h0;
            next_st = CCS_ACK;
            next_ack_ok = 1'b0;
            case (kind)
              CCS_K_ADDR: begin
                if (shreg[7:1] == {CCS_ADDR_BASE, r01[1:0]}) begin // RQ12
                  next_ack_ok = 1'b1;
                  next_sda_low = 1'b1;
                  next_is_read = shreg[0];
                end
              end
              CCS_K_CMD: begin
                next_offset = shreg[6:0]; // RQ16
                next_single = shreg[CCS_BIT_SINGLE]; // RQ16
                next_wrote = 1'b0;
                next_ack_ok = 1'b1;
                next_sda_low = 1'b1;
              end
              default: begin
                // Refused bytes are not acknowledged and not stored
                if (!nvm_programming_active_in && !(single && wrote)) begin // RQ18
                  wr_en = 1'b1; // RQ17
                  next_offset = offset + 7'h01;
                  next_wrote = 1'b1;
                  next_ack_ok = 1'b1;
                  next_sda_low = 1'b1;
                end
              end
            endcase
          end
        end
        CCS_ACK: begin
          if (scl_fall) begin
            next_sda_low = 1'b0;
            if (!ack_ok) begin
              next_st = CCS_IDLE;
            end else if (is_read) begin
              next_shreg = rd_byte;
              next_sda_low = ~rd_byte[7];
              next_bcnt = 4'h0;
              next_st = CCS_SEND;
            end else begin
              next_st = CCS_RECV;
              next_kind = (kind == CCS_K_ADDR) ? CCS_K_CMD : CCS_K_DATA;
            end
          end
        end
        CCS_SEND: begin
          if (scl_rise) begin
            next_bcnt = bcnt + 4'h1;
          end else if (scl_fall) begin
            if (bcnt == CCS_BYTE_BITS) begin
              next_sda_low = 1'b0;
              next_st = CCS_RACK;
              next_offset = offset + 7'h01;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_sda_low = ~shreg[6];
            end
          end
        end
        CCS_RACK: begin
          if (scl_rise) begin
            next_ack_ok = ~filt[0];
          end else if (scl_fall) begin
            if (ack_ok) begin
              next_shreg = rd_byte;
              next_sda_low = ~rd_byte[7];
              next_bcnt = 4'h0;
              next_st = CCS_SEND;
            end else begin
              next_st = CCS_IDLE;
            end
          end
        end
        default: next_st = CCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= CCS_IDLE;
      kind <= CCS_K_ADDR;
      bcnt <= 4'h0;
      shreg <= 8'h00;
      offset <= 7'h00;
      is_read <= 1'b0;
      single <= 1'b0;
      wrote <= 1'b0;
      ack_ok <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      st <= next_st;
      kind <= next_kind;
      bcnt <= next_bcnt;
      shreg <= next_shreg;
      offset <= next_offset;
      is_read <= next_is_read;
      single <= next_single;
      wrote <= next_wrote;
      ack_ok <= next_ack_ok;
      sda_low <= next_sda_low;
    end
  end

  // ----------------------------------------------------------------
  // Setting selection and outputs
  // ----------------------------------------------------------------
  logic [2:0] idx;
  logic b_rsvd, pdn;
  ccs_pll_sel_t next_sel;

  // Dual pins read as zero while they serve the serial port
  assign idx = {pin_role_active_out & filt[1], pin_role_active_out & filt[0], filt[2]}; // RQ3
  assign b_rsvd = (idx == CCS_B_RSVD_LO) || (idx == CCS_B_RSVD_HI);
  assign pdn = r01[CCS_BIT_PDN];

  always_comb begin
    next_sel.a_freq = r13[idx]; // RQ4
    next_sel.a_state = r15[idx] & ~pdn; // RQ8
    next_sel.b_freq = b_rsvd ? 1'b0 : r23[idx]; // RQ4
    next_sel.b_state = (b_rsvd | pdn) ? 1'b0 : r25[idx]; // RQ4
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
      pll_settings_out <= '0;
      pll_power_down_out <= 1'b0;
      outputs_hiz_out <= 1'b0;
      input_clock_source_out <= 2'h0;
      output_source_select_out <= 1'b0;
      nvm_permanent_lock_out <= 1'b0;
      pin_role_active_out <= 1'b0;
      nvm_ctrl_image_out <= 8'h00;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n_out <= ~sda_low;
      pll_settings_out <= next_sel;
      pll_power_down_out <= pdn; // RQ9
      outputs_hiz_out <= pdn; // RQ9
      input_clock_source_out <= r01[3:2]; // RQ11
      output_source_select_out <= r02[CCS_BIT_OUTSRC]; // RQ14
      nvm_permanent_lock_out <= r01[CCS_BIT_LOCK]; // RQ7
      pin_role_active_out <= nvm_pin_role_in; // RQ19
      nvm_ctrl_image_out <= {r01[7:5], 1'b0, r01[3:0]}; // RQ10
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wr_a_freq;
    wr_en && wr_off == CCS_OFF_A_FREQ;
  endsequence
  sequence s_pdn_held;
    pdn && !wr_en;
  endsequence
  property p_write_now;
    @(posedge clk_in) disable iff (!rst_n_in) s_wr_a_freq |=> r13 == $past(wr_data);
  endproperty
  a_write_now: assert property (p_write_now) else $error("byte not stored"); // RQ17
  property p_pd_off;
    @(posedge clk_in) disable iff (!rst_n_in)
      pdn |=> pll_power_down_out && outputs_hiz_out && !pll_settings_out.b_state;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("power-down not applied"); // RQ9
  property p_active;
    @(posedge clk_in) disable iff (!rst_n_in) !pdn |=> !pll_power_down_out && !outputs_hiz_out;
  endproperty
  a_active: assert property (p_active) else $error("device not active"); // RQ9
  property p_pd_keeps;
    @(posedge clk_in) disable iff (!rst_n_in) s_pdn_held |=> $stable(r13) && $stable(r25);
  endproperty
  a_pd_keeps: assert property (p_pd_keeps) else $error("configuration changed"); // RQ8
  property p_image;
    @(posedge clk_in) disable iff (!rst_n_in) !nvm_ctrl_image_out[CCS_BIT_PDN];
  endproperty
  a_image: assert property (p_image) else $error("power-down in NVM image"); // RQ10
  property p_busy;
    @(posedge clk_in) disable iff (!rst_n_in) nvm_programming_active_in |-> !wr_en;
  endproperty
  a_busy: assert property (p_busy) else $error("write during NVM cycle"); // RQ18
  property p_ro_bits;
    @(posedge clk_in) disable iff (!rst_n_in) r01[7] == 1'b0 && r02[5:0] == 6'h00;
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("read-only bit stored"); // RQ20
  property p_b_rsvd;
    @(posedge clk_in) disable iff (!rst_n_in)
      b_rsvd |=> !pll_settings_out.b_freq && !pll_settings_out.b_state;
  endproperty
  a_b_rsvd: assert property (p_b_rsvd) else $error("reserved index used"); // RQ4
  property p_pins_masked;
    @(posedge clk_in) disable iff (!rst_n_in) !pin_role_active_out |-> idx[2:1] == 2'h0;
  endproperty
  a_pins_masked: assert property (p_pins_masked) else $error("serial pins as control"); // RQ15
endmodule

// ==== tb/ccs_master.sv ====
// Serial bus master model that drives the register bank's two-wire port.
// Assumes the bench resolves the pulled-up data line and clocks clk_in at 10 MHz.
`timescale 1ns/1ps
module ccs_master (
  input wire logic clk_in,
  input wire logic sda_line_in,
  output logic scl_out,
  output logic sda_out
);
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  // Clock stands high between frames; a released data line floats to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Also serves as repeated start while the clock is low
  task automatic start_bit();
    sda_out = 1'b1;
    wait_n(6);
    scl_out = 1'b1;
    wait_n(4);
    sda_out = 1'b0;
    wait_n(4);
    scl_out = 1'b0;
    wait_n(2);
  endtask
  task automatic stop_bit();
    sda_out = 1'b0;
    wait_n(2);
    scl_out = 1'b1;
    wait_n(4);
    sda_out = 1'b1;
    wait_n(4);
  endtask
  // Six cycles low, two high: the slave answers about five cycles after
  // the pin falls, so a shorter low phase would move its data into the high phase
  task automatic bit_io(input logic b, output logic s);
    wait_n(1);
    sda_out = b;
    wait_n(5);
    scl_out = 1'b1;
    wait_n(2);
    s = sda_line_in;
    scl_out = 1'b0;
  endtask
  // Most significant bit first; the ninth bit sends mack and returns the line
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, ack_n);
  endtask
endmodule

// ==== tb/tb_ccs_regs.sv ====
// Self-checking bench for the register bank, driven through its serial port.
// Assumes ccs_pkg and the bus master model are compiled before this file.
`timescale 1ns/1ps
module tb_ccs_regs;
  import ccs_pkg::*;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  localparam logic [7:0] tbl_a = 8'haa;
  localparam logic [7:0] tbl_as = 8'h55;
  localparam logic [7:0] tbl_b = 8'h5a;
  localparam logic [7:0] tbl_bs = 8'hff;
  logic clk, rst_n, pin0, nvm_busy, nvm_role, pin_mode;
  logic [2:1] pins_hi;
  logic scl_m, sda_m, sda_drv, sda_oe_n, sda_line;
  ccs_pll_sel_t sets;
  logic pd, hiz, osel, lock, role, ack_n;
  logic [1:0] clksrc;
  logic [7:0] image, rx;
  logic [6:0] dev;
  int error_cnt, samples_checked;
  // Open-drain data line with pull-up
  assign sda_line = sda_m & (sda_oe_n | sda_drv);
  ccs_master partner (.clk_in(clk), .sda_line_in(sda_line), .scl_out(scl_m), .sda_out(sda_m));
  ccs_regs uut (
    .clk_in(clk), .rst_n_in(rst_n),
    .scl_in(pin_mode ? pins_hi[2] : scl_m), .sda_in(pin_mode ? pins_hi[1] : sda_line),
    .ctrl_pin_zero_in(pin0), .nvm_programming_active_in(nvm_busy),
    .nvm_pin_role_in(nvm_role), .sda_out(sda_drv), .sda_oe_n_out(sda_oe_n),
    .pll_settings_out(sets), .pll_power_down_out(pd), .outputs_hiz_out(hiz),
    .input_clock_source_out(clksrc), .output_source_select_out(osel),
    .nvm_permanent_lock_out(lock), .pin_role_active_out(role), .nvm_ctrl_image_out(image)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    partner.xfer(b, 1'b1, rx, ack_n);
    chk("ack", {7'h0, ack_n}, {7'h0, ~exp_ack});
  endtask
  task automatic wr(input logic [6:0] off, input logic [7:0] d, input logic data_ack);
    partner.start_bit();
    send({dev, 1'b0}, 1'b1);
    send({1'b1, off}, 1'b1);
    send(d, data_ack);
    partner.stop_bit();
  endtask
  task automatic rd(input logic [6:0] off, input logic [7:0] exp);
    partner.start_bit();
    send({dev, 1'b0}, 1'b1);
    send({1'b1, off}, 1'b1);
    partner.start_bit();
    send({dev, 1'b1}, 1'b1);
    partner.xfer(8'hff, 1'b1, rx, ack_n);
    partner.stop_bit();
    chk("read", rx, exp);
  endtask
  task automatic set_idx(input int i);
    pins_hi = i[2:1];
    pin0 = i[0];
    partner.wait_n(8);
  endtask
  function automatic logic [7:0] exp_set(input int i, input logic pdn);
    logic rsv;
    rsv = (i == 3) || (i == 4);
    return {4'h0, tbl_a[i], tbl_as[i] & ~pdn, tbl_b[i] & ~rsv, tbl_bs[i] & ~rsv & ~pdn};
  endfunction
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    pin0 = 1'b0;
    nvm_busy = 1'b0;
    nvm_role = 1'b0;
    pin_mode = 1'b0;
    pins_hi = 2'h3;
    dev = {CCS_ADDR_BASE, 2'h0};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    partner.wait_n(6);
    chk("reset pins", {pd, hiz, osel, lock, role, clksrc, sda_oe_n}, 8'h01);
    chk("reset image", image, 8'h00);
    chk("reset settings", {4'h0, sets}, 8'h00);
    rd(7'h00, 8'ha5);
    wr(7'h00, 8'h3c, 1'b1);
    rd(7'h00, 8'ha5);
    partner.start_bit();
    send({dev + 7'h1, 1'b0}, 1'b0);
    partner.stop_bit();
    // Block write starts above byte zero so the identity byte is never touched
    partner.start_bit();
    send({dev, 1'b0}, 1'b1);
    send({1'b0, CCS_OFF_A_FREQ}, 1'b1);
    send(tbl_a, 1'b1);
    send(8'h00, 1'b1);
    send(tbl_as, 1'b1);
    partner.stop_bit();
    wr(CCS_OFF_B_FREQ, tbl_b, 1'b1);
    wr(CCS_OFF_B_STATE, tbl_bs, 1'b1);
    partner.start_bit();
    send({dev, 1'b0}, 1'b1);
    send({1'b0, CCS_OFF_A_FREQ}, 1'b1);
    partner.start_bit();
    send({dev, 1'b1}, 1'b1);
    partner.xfer(8'hff, 1'b0, rx, ack_n);
    chk("block read 0", rx, tbl_a);
    partner.xfer(8'hff, 1'b0, rx, ack_n);
    chk("block read 1", rx, 8'h00);
    partner.xfer(8'hff, 1'b1, rx, ack_n);
    chk("block read 2", rx, tbl_as);
    partner.stop_bit();
    // Serial lines idle high must not reach the setting index
    for (int i = 0; i < 2; i++) begin
      pin0 = i[0];
      partner.wait_n(8);
      chk("serial mode setting", {4'h0, sets}, exp_set(i, 1'b0));
    end
    nvm_role = 1'b1;
    partner.wait_n(4);
    chk("pin role", {7'h0, role}, 8'h01);
    pin_mode = 1'b1;
    for (int i = 0; i < 8; i++) begin
      set_idx(i);
      chk("setting", {4'h0, sets}, exp_set(i, 1'b0));
    end
    set_idx(1);
    pin_mode = 1'b0;
    partner.wait_n(6);
    nvm_role = 1'b0;
    partner.wait_n(6);
    wr(CCS_OFF_CTRL, 8'h7f, 1'b1);
    dev = {CCS_ADDR_BASE, 2'h3};
    chk("ctrl outputs", {pd, hiz, lock, clksrc, 3'h0}, 8'hf8);
    chk("nvm image", image, 8'h2f);
    chk("powered down setting", {4'h0, sets}, exp_set(1, 1'b1));
    rd(CCS_OFF_CTRL, 8'h3f);
    partner.start_bit();
    send({CCS_ADDR_BASE, 2'h0, 1'b0}, 1'b0);
    partner.stop_bit();
    wr(CCS_OFF_CTRL, 8'h00, 1'b1);
    dev = {CCS_ADDR_BASE, 2'h0};
    chk("power up", {pd, hiz, 2'h0, sets}, exp_set(1, 1'b0));
    rd(CCS_OFF_A_FREQ, tbl_a);
    wr(CCS_OFF_OUTSEL, 8'hff, 1'b1);
    chk("output source", {6'h0, osel, role}, 8'h02);
    rd(CCS_OFF_OUTSEL, 8'hc0);
    partner.start_bit();
    send({dev, 1'b0}, 1'b1);
    send({1'b1, CCS_OFF_A_STATE}, 1'b1);
    send(8'h33, 1'b1);
    send(8'h44, 1'b0);
    partner.stop_bit();
    rd(CCS_OFF_A_STATE, 8'h33);
    nvm_busy = 1'b1;
    partner.wait_n(2);
    wr(CCS_OFF_A_FREQ, 8'h00, 1'b0);
    rd(CCS_OFF_A_FREQ, tbl_a);
    rd(CCS_OFF_CTRL, 8'h40);
    nvm_busy = 1'b0;
    partner.wait_n(2);
    rd(CCS_OFF_CTRL, 8'h00);
    rd(7'h30, 8'h00);
    rst_n = 1'b0;
    partner.wait_n(3);
    rst_n = 1'b1;
    partner.wait_n(6);
    chk("data drive", {7'h0, sda_drv}, 8'h00);
    chk("mid reset pins", {pd, hiz, osel, lock, role, clksrc, sda_oe_n}, 8'h01);
    rd(CCS_OFF_A_FREQ, 8'h00);
    wrap_up();
  end
endmodule
